// ---- adc_result_pkg.sv ----
// adc_result_pkg: offsets, field positions and carriers for the adc result pair bank.
// assumes a 32-bit apb master and a conversion sequencer on the same clock.
package adc_result_pkg;

   localparam int unsigned num_pairs = 4;
   localparam int unsigned result_width = 10;

   // printed offsets are not all multiples of four: they are register indices
   localparam logic [31:0] result_five_low_idx = 32'hfffff30a;
   localparam logic [31:0] result_five_high_idx = 32'hfffff30b;
   localparam logic [31:0] result_six_low_idx = 32'hfffff30c;
   localparam logic [31:0] result_six_high_idx = 32'hfffff30d;
   localparam logic [31:0] result_seven_low_idx = 32'hfffff30e;
   localparam logic [31:0] result_seven_high_idx = 32'hfffff30f;
   localparam logic [31:0] priority_result_low_idx = 32'hfffff310;
   localparam logic [31:0] priority_result_high_idx = 32'hfffff311;
   // byte address = index * 4, so only the low 30 index bits survive
   localparam logic [31:0] bank_base_idx = result_five_low_idx;
   localparam logic [31:0] bank_last_idx = priority_result_high_idx;

   // pair numbers on the write side
   localparam logic [1:0] pair_five = 2'h0;
   localparam logic [1:0] pair_six = 2'h1;
   localparam logic [1:0] pair_seven = 2'h2;
   localparam logic [1:0] pair_priority = 2'h3;

   // lower byte layout
   localparam int unsigned stored_flag_bit = 0;
   localparam int unsigned overrun_flag_bit = 1;
   localparam int unsigned low_result_lsb = 6;
   localparam logic [7:0] low_unused_ones = 8'h3c;
   localparam logic stored_flag_reset = 1'b0;
   localparam logic overrun_flag_reset = 1'b0;

   typedef struct packed {
      logic valid;
      logic priority_conv;
      logic [1:0] channel;
      logic [result_width-1:0] value;
   } result_write_s;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

endpackage

// ---- adc_result_store.sv ----
// adc_result_store: small memory of result words, one per pair, registered read.
// assumes one write and one read port on the same clock; contents undefined at reset.
`timescale 1ns/1ns
`default_nettype none
module adc_result_store #(
   parameter int unsigned depth = 4,
   parameter int unsigned width = 10
) (
   input wire logic i_clk,
   input wire logic i_wr_en,
   input wire logic [$clog2(depth)-1:0] i_wr_addr,
   input wire logic [width-1:0] i_wr_data,
   input wire logic [$clog2(depth)-1:0] i_rd_addr,
   output logic [width-1:0] o_rd_data
);
   logic [width-1:0] mem [depth];

   // no reset: result bits are undefined after reset by design
   always_ff @(posedge i_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end
endmodule
`default_nettype wire

// ---- adc_result_regs.sv ----
// adc_result_regs: apb register bank of four adc result pairs with stored and overrun flags.
// assumes a 32-bit apb master on i_clk and a sequencer writing results as one-cycle strobes.
// Notes on behaviour
// - result bits 1:0 in lower byte 7:6
// - result bits 9:2 in upper byte
// - new result sets stored flag
// - reading lower byte clears stored flag
// - result before both bytes read sets overrun
// - reading overrun flag clears it
// - lower byte bits 5:2 read as ones
// - flags reset zero, results undefined
// - priority conversions go to priority pair
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module adc_result_regs (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire adc_result_pkg::apb_req_s i_apb,
   output var adc_result_pkg::apb_rsp_s o_apb,
   input wire adc_result_pkg::result_write_s i_result,
   output logic [adc_result_pkg::num_pairs-1:0] o_stored_flag,
   output logic [adc_result_pkg::num_pairs-1:0] o_overrun_flag
);

   localparam int unsigned np = adc_result_pkg::num_pairs;

   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_fetch = 2'b01,
      bus_answer = 2'b10
   } bus_state_e;

   typedef struct packed {
      bus_state_e bus;
      logic [np-1:0] stored;
      logic [np-1:0] overrun;
      logic [np-1:0] low_read;
      logic [np-1:0] high_read;
      logic [1:0] rd_pair;
      logic rd_high;
      logic rd_hit;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // result memory

   logic wr_en;
   logic [1:0] wr_pair;
   logic [adc_result_pkg::result_width-1:0] rd_value;

   always_comb begin
      wr_en = i_result.valid;
      // priority results never land in a channel pair
      if (i_result.priority_conv) begin
         wr_pair = adc_result_pkg::pair_priority;
      end else begin
         wr_pair = i_result.channel;
      end
   end

   // a write always overwrites, so an overrun keeps the newest value
   adc_result_store #(
      .depth(np),
      .width(adc_result_pkg::result_width)
   ) u_store (
      .i_clk(i_clk),
      .i_wr_en(wr_en),
      .i_wr_addr(wr_pair),
      .i_wr_data(i_result.value),
      // addressed on the setup edge so the word stands during the fetch cycle
      .i_rd_addr(state_nxt.rd_pair),
      .o_rd_data(rd_value)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   logic [29:0] idx;
   logic [29:0] offset;
   logic in_range;
   logic aligned;

   always_comb begin
      idx = i_apb.paddr[31:2];
      offset = idx - adc_result_pkg::bank_base_idx[29:0];
      aligned = (i_apb.paddr[1:0] == 2'h0);
      in_range = aligned && (idx >= adc_result_pkg::bank_base_idx[29:0])
         && (idx <= adc_result_pkg::bank_last_idx[29:0]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-pair write and read events

   logic [np-1:0] pair_wr;
   logic [np-1:0] pair_unread;
   logic [np-1:0] pair_low_clr;
   logic [np-1:0] pair_high_mark;
   logic rd_done;

   // read side effects take hold on the completing edge only
   assign rd_done = (state_r.bus == bus_answer) && state_r.rd_hit && !i_apb.pwrite;

   for (genvar g = 0; g < np; g++) begin : g_pair
      assign pair_wr[g] = wr_en && (wr_pair == 2'(g));
      // some byte of the pair still waits for software since the last write
      assign pair_unread[g] = !(state_r.low_read[g] && state_r.high_read[g]);
      assign pair_low_clr[g] = rd_done && !state_r.rd_high && (state_r.rd_pair == 2'(g));
      assign pair_high_mark[g] = rd_done && state_r.rd_high && (state_r.rd_pair == 2'(g));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   logic [7:0] low_byte;
   logic [7:0] high_byte;
   logic [1:0] p;

   always_comb begin
      state_nxt = state_r;
      p = state_r.rd_pair;
      low_byte = adc_result_pkg::low_unused_ones;
      low_byte[7:adc_result_pkg::low_result_lsb] = rd_value[1:0];
      low_byte[adc_result_pkg::overrun_flag_bit] = state_r.overrun[p];
      low_byte[adc_result_pkg::stored_flag_bit] = state_r.stored[p];
      high_byte = rd_value[adc_result_pkg::result_width-1:2];
      state_nxt.pready = 1'b0;
      state_nxt.pslverr = 1'b0;

      case (state_r.bus)
         bus_idle: begin
            // setup seen: latch the decode, memory read takes one cycle
            if (i_apb.psel && !i_apb.penable) begin
               state_nxt.rd_pair = offset[2:1];
               state_nxt.rd_high = offset[0];
               state_nxt.rd_hit = in_range;
               state_nxt.bus = bus_fetch;
            end
         end
         bus_fetch: begin
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = !state_r.rd_hit;
            state_nxt.prdata = 32'h0;
            // registers are read-only; writes are accepted and ignored
            if (state_r.rd_hit && !i_apb.pwrite) begin
               state_nxt.prdata[7:0] = state_r.rd_high ? high_byte : low_byte;
            end
            state_nxt.bus = bus_answer;
         end
         bus_answer: begin
            state_nxt.bus = bus_idle;
         end
         default: begin
            state_nxt.bus = bus_idle;
         end
      endcase

      // a write lands after any read clear so the set wins
      state_nxt.stored = state_r.stored & ~pair_low_clr;
      state_nxt.stored = state_nxt.stored | pair_wr;
      state_nxt.overrun = state_r.overrun & ~pair_low_clr;
      state_nxt.overrun = state_nxt.overrun | (pair_wr & pair_unread);
      state_nxt.low_read = (state_r.low_read | pair_low_clr) & ~pair_wr;
      state_nxt.high_read = (state_r.high_read | pair_high_mark) & ~pair_wr;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r.bus <= bus_idle;
         state_r.stored <= {np{adc_result_pkg::stored_flag_reset}};
         state_r.overrun <= {np{adc_result_pkg::overrun_flag_reset}};
         // an empty pair counts as fully read, so its first result is no overrun
         state_r.low_read <= '1;
         state_r.high_read <= '1;
         state_r.rd_pair <= 2'h0;
         state_r.rd_high <= 1'b0;
         state_r.rd_hit <= 1'b0;
         state_r.prdata <= 32'h0;
         state_r.pready <= 1'b0;
         state_r.pslverr <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_comb begin
      o_apb.prdata = state_r.prdata;
      o_apb.pready = state_r.pready;
      o_apb.pslverr = state_r.pslverr;
      o_stored_flag = state_r.stored;
      o_overrun_flag = state_r.overrun;
   end

endmodule
`default_nettype wire

// ---- adc_seq_model.sv ----
// conversion sequencer stand-in: turns a bench request into a one-cycle result strobe.
// assumes requests are held for one cycle, on the bank's clock.
`timescale 1ns/1ns
`default_nettype none
module adc_seq_model (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_go,
   input wire logic i_pri,
   input wire logic [1:0] i_ch,
   input wire logic [9:0] i_val,
   output var adc_result_pkg::result_write_s o_result
);
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_result <= '0;
      end else begin
         o_result.valid <= i_go;
         o_result.priority_conv <= i_pri;
         o_result.channel <= i_ch;
         // idle value toggles so a stale sample never looks right
         o_result.value <= i_go ? i_val : ~o_result.value;
      end
   end
endmodule
`default_nettype wire

// ---- adc_result_regs_asserts.sv ----
// checker: apb timing and flag behaviour of the result pair bank.
// assumes it is bound onto adc_result_regs.
`timescale 1ns/1ns
`default_nettype none
module adc_result_regs_asserts (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire adc_result_pkg::apb_req_s i_apb,
   input wire adc_result_pkg::apb_rsp_s o_apb,
   input wire adc_result_pkg::result_write_s i_result,
   input wire logic [adc_result_pkg::num_pairs-1:0] o_stored_flag,
   input wire logic [adc_result_pkg::num_pairs-1:0] o_overrun_flag
);
   logic [3:0] off;
   logic rd_low;
   // pair number is bits 2:1 of index minus the first index
   assign off = i_apb.paddr[5:2] - 4'ha;
   assign rd_low = o_apb.pready && !o_apb.pslverr && !i_apb.pwrite && !i_apb.paddr[2];
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_ready_wait: assert property (i_apb.psel && !i_apb.penable |-> ##2 o_apb.pready)
      else $error("pready not two cycles after setup");
   a_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("pready longer than one cycle");
   a_err_data: assert property (o_apb.pready |-> o_apb.prdata[31:8] == 24'h0
      && (!o_apb.pslverr || o_apb.prdata == 32'h0)) else $error("read data not zeroed");
   a_stored_set: assert property (i_result.valid && !i_result.priority_conv |=>
      o_stored_flag[$past(i_result.channel)]) else $error("stored flag not set");
   a_priority_pair: assert property (i_result.valid && i_result.priority_conv |=>
      o_stored_flag[3]) else $error("priority pair not written");
   a_low_ones: assert property (rd_low |-> o_apb.prdata[5:2] == 4'hf)
      else $error("unused bits not ones");
   a_stored_clear: assert property (rd_low && !i_result.valid |=>
      !o_stored_flag[$past(off[2:1])]) else $error("stored flag not cleared");
   a_overrun_clear: assert property (rd_low && !i_result.valid |=>
      !o_overrun_flag[$past(off[2:1])]) else $error("overrun flag not cleared");
   a_overrun_cause: assert property ((o_overrun_flag & ~$past(o_overrun_flag)) != 4'h0
      |-> $past(i_result.valid)) else $error("overrun without a result");
   cover property (o_overrun_flag != 4'h0);
   cover property (o_apb.pready && o_apb.pslverr);
   cover property (i_result.valid && i_result.priority_conv);
endmodule
bind adc_result_regs adc_result_regs_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_apb(i_apb), .o_apb(o_apb), .i_result(i_result), .o_stored_flag(o_stored_flag),
   .o_overrun_flag(o_overrun_flag));
`default_nettype wire

// ---- testbench.sv ----
// bench: drives apb reads and sequencer results, compares with a pair model.
// assumes the bank, its checker and the sequencer stand-in are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic i_clk, i_reset_n, go, pri, e;
   logic [1:0] ch;
   logic [9:0] val;
   logic [3:0] stored_flag, overrun_flag, st, ov, rl, rh;
   logic [9:0] vals [4];
   logic [31:0] seed, d;
   int failures, checks, cyc;
   adc_result_pkg::apb_req_s req;
   adc_result_pkg::apb_rsp_s rsp;
   adc_result_pkg::result_write_s res;
   adc_result_regs uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(req), .o_apb(rsp),
      .i_result(res), .o_stored_flag(stored_flag), .o_overrun_flag(overrun_flag));
   adc_seq_model seq (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_pri(pri),
      .i_ch(ch), .i_val(val), .o_result(res));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] ad(input int p, input int hi);
      return (adc_result_pkg::result_five_low_idx + 32'(2 * p + hi)) << 2;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic [31:0] a, input logic w);
      int n;
      @(posedge i_clk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: 32'hffffffff};
      @(posedge i_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      d = rsp.prdata;
      e = rsp.pslverr;
      if (n >= 20) failures++;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input int p, input int hi);
      logic [31:0] exp;
      apb(ad(p, hi), 1'b0);
      exp = hi ? {24'h0, vals[p][9:2]} : {24'h0, vals[p][1:0], 4'hf, ov[p], st[p]};
      chk(d, exp);
      if (hi) rh[p] = 1'b1;
      else {st[p], ov[p], rl[p]} = 3'b001;
   endtask
   task automatic conv(input int p, input logic pr, input logic [9:0] v);
      int t;
      logic [31:0] r;
      r = xs();
      @(posedge i_clk);
      chk({28'h0, stored_flag}, {28'h0, st});
      chk({28'h0, overrun_flag}, {28'h0, ov});
      go <= 1'b1;
      pri <= pr;
      ch <= pr ? r[1:0] : 2'(p);
      val <= v;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (2) @(posedge i_clk);
      t = pr ? 3 : p;
      if (!(rl[t] && rh[t])) ov[t] = 1'b1;
      {st[t], rl[t], rh[t]} = 3'b100;
      vals[t] = v;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      {i_reset_n, go, pri, ch, val, st, ov} = '0;
      // an empty pair counts as fully read
      {rl, rh} = 8'hff;
      req = '0;
      seed = 32'd67;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         conv(p, p == 3, 10'(xs()));
         rd(p, 0);
         conv(p, p == 3, 10'(xs()));
         rd(p, 1);
         rd(p, 0);
         rd(p, 0);
      end
      // channel 3 without the priority bit also lands in the priority pair
      for (int p = 0; p < 4; p++) begin
         conv(p, 1'b0, 10'(xs()));
         rd(p, 1);
         conv(p, p == 3, 10'(xs()));
         conv(p, 1'b0, 10'(xs()));
         rd(p, 0);
         rd(p, 0);
      end
      conv(0, 1'b0, 10'(xs()));
      apb(ad(0, 0), 1'b1);
      chk(d, 32'h0);
      rd(0, 0);
      apb(ad(4, 0), 1'b0);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
      conv(0, 1'b0, 10'(xs()));
      rd(0, 0);
      close_out();
   end
endmodule
`default_nettype wire
